/* File: rtl/alsi_consts.svh */
// constants for the light sensor status and power-save refresh block
// assumes inclusion by bare name from the block's top module
`ifndef ALSI_CONSTS_SVH
`define ALSI_CONSTS_SVH
`define ALSI_CMD_LOW_TH 8'h02
`define ALSI_CMD_PSAVE 8'h03
`define ALSI_CMD_STATUS 8'h06
`define ALSI_LOW_BIT 15
`define ALSI_HIGH_BIT 14
`define ALSI_RSV_MSB 13
`define ALSI_WAIT_MSB 2
`define ALSI_WAIT_LSB 1
`define ALSI_PSON_BIT 0
`define ALSI_LOW_TH_RST 16'h0000
`define ALSI_PSAVE_RST 3'h0
`define ALSI_ZERO16 16'h0000
`define ALSI_GAIN_NOM 2'h1
`define ALSI_IT_0 4'h0
`define ALSI_IT_1 4'h1
`define ALSI_IT_2 4'h2
`define ALSI_WAIT_0 2'h0
`define ALSI_WAIT_1 2'h1
`define ALSI_WAIT_2 2'h2
// refresh base per wait code, ms
`define ALSI_BASE_W0 13'd600
`define ALSI_BASE_W1 13'd1100
`define ALSI_BASE_W2 13'd2100
`define ALSI_BASE_W3 13'd4100
// extra refresh per integration code, ms
`define ALSI_ADD_IT0 13'd0
`define ALSI_ADD_IT1 13'd100
`define ALSI_ADD_IT2 13'd300
`define ALSI_ADD_IT3 13'd700
// count resolution in units of 0.0001 lx
`define ALSI_RES_IT0 16'd288
`define ALSI_RES_IT1 16'd144
`define ALSI_RES_IT2 16'd72
`define ALSI_RES_IT3 16'd36
// one millisecond and the clock period, ns
`define ALSI_MS_NS 1000000
`define ALSI_CLK_NS 20
`define ALSI_ONE13 13'h0001
`define ALSI_ONE16 16'h0001
`endif

/* File: rtl/alsi_pkg.sv */
// types for the light sensor status and power-save refresh block
// assumes nothing of its surroundings
package alsi_pkg;
  typedef enum logic [1:0] {
    ALSI_IDLE = 2'b01,
    ALSI_RUN = 2'b10
  } alsi_state_e;
  typedef logic [12:0] alsi_ms_t;
endpackage

/* File: rtl/alsi_top.sv */
// threshold crossing status register and power-save refresh timer
// assumes a host command port synchronous to ref_clk and a result strobe from the converter
// Operation
// - status register at command 06h tells host which window crossing interrupted.
// - bit 15 sets when the result crosses below the low threshold.
// - bit 14 sets when the result crosses above the high threshold.
// - both flags read-only; bits 13 to 0 reserved, read zero.
// - in power-save mode refresh period comes from wait and integration codes.
// - integration 0000 refreshes every 600, 1100, 2100, 4100 ms per wait code.
// - integration 0001..0011 add 100, 300, 700 ms, at most 4800 ms.
// - gain 01 count scales 0.0288 to 0.0036 lx per integration code.
// - command 03h holds wait code in bits 2:1, enable in bit 0.
// - low bound comes from command 02h register once interrupts enabled.
`timescale 1ns/1ps
`default_nettype none
`include "alsi_consts.svh"
module alsi_top #(
  parameter int MS_CYCLES = `ALSI_MS_NS / `ALSI_CLK_NS
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  output logic cmd_rvalid,
  input wire logic result_valid,
  input wire logic [15:0] light_result,
  input wire logic [15:0] high_threshold,
  input wire logic int_enable,
  input wire logic [3:0] integration_time_code,
  input wire logic [1:0] gain_code,
  output logic refresh_pulse,
  output logic [12:0] refresh_period_ms,
  output logic [15:0] lx_per_count,
  output logic lx_scale_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // lookup functions

  function automatic alsi_pkg::alsi_ms_t period_ms(input logic [1:0] wait_c,
                                                    input logic [3:0] it_c);
    alsi_pkg::alsi_ms_t base;
    alsi_pkg::alsi_ms_t add;
    base = `ALSI_BASE_W3;
    add = `ALSI_ADD_IT3;
    case (wait_c)
      `ALSI_WAIT_0: base = `ALSI_BASE_W0;
      `ALSI_WAIT_1: base = `ALSI_BASE_W1;
      `ALSI_WAIT_2: base = `ALSI_BASE_W2;
      default: base = `ALSI_BASE_W3;
    endcase
    case (it_c)
      `ALSI_IT_0: add = `ALSI_ADD_IT0;
      `ALSI_IT_1: add = `ALSI_ADD_IT1;
      `ALSI_IT_2: add = `ALSI_ADD_IT2;
      default: add = `ALSI_ADD_IT3;
    endcase
    period_ms = base + add;
  endfunction

  function automatic logic [15:0] res_of(input logic [3:0] it_c);
    case (it_c)
      `ALSI_IT_0: res_of = `ALSI_RES_IT0;
      `ALSI_IT_1: res_of = `ALSI_RES_IT1;
      `ALSI_IT_2: res_of = `ALSI_RES_IT2;
      default: res_of = `ALSI_RES_IT3;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // command registers and status flags

  logic [15:0] low_th_reg, low_th_next;
  logic [2:0] psave_reg, psave_next;
  logic low_crossing_flag_reg, low_crossing_flag_next;
  logic high_crossing_flag_reg, high_crossing_flag_next;
  logic [15:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic low_hit, high_hit, status_rd;
  logic [15:0] threshold_interrupt_flags;

  always_comb begin
    low_hit = result_valid && int_enable && (light_result < low_th_reg);
    high_hit = result_valid && int_enable && (light_result > high_threshold);
    status_rd = cmd_rd && (cmd_code == `ALSI_CMD_STATUS);
    threshold_interrupt_flags = `ALSI_ZERO16;
    threshold_interrupt_flags[`ALSI_LOW_BIT] = low_crossing_flag_reg;
    threshold_interrupt_flags[`ALSI_HIGH_BIT] = high_crossing_flag_reg;
    low_th_next = low_th_reg;
    psave_next = psave_reg;
    if (cmd_wr && cmd_code == `ALSI_CMD_LOW_TH) begin
      low_th_next = cmd_wdata;
    end
    if (cmd_wr && cmd_code == `ALSI_CMD_PSAVE) begin
      psave_next = cmd_wdata[`ALSI_WAIT_MSB:`ALSI_PSON_BIT];
    end
    low_crossing_flag_next = low_crossing_flag_reg && !status_rd;
    high_crossing_flag_next = high_crossing_flag_reg && !status_rd;
    if (low_hit) begin
      low_crossing_flag_next = 1'b1;
    end
    if (high_hit) begin
      high_crossing_flag_next = 1'b1;
    end
    rvalid_next = cmd_rd;
    rdata_next = `ALSI_ZERO16;
    if (cmd_rd) begin
      case (cmd_code)
        `ALSI_CMD_LOW_TH: rdata_next = low_th_reg;
        `ALSI_CMD_PSAVE: rdata_next = {13'h0000, psave_reg};
        `ALSI_CMD_STATUS: rdata_next = threshold_interrupt_flags;
        default: rdata_next = `ALSI_ZERO16;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      low_th_reg <= `ALSI_LOW_TH_RST;
      psave_reg <= `ALSI_PSAVE_RST;
      low_crossing_flag_reg <= 1'b0;
      high_crossing_flag_reg <= 1'b0;
      rdata_reg <= `ALSI_ZERO16;
      rvalid_reg <= 1'b0;
    end else begin
      low_th_reg <= low_th_next;
      psave_reg <= psave_next;
      low_crossing_flag_reg <= low_crossing_flag_next;
      high_crossing_flag_reg <= high_crossing_flag_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-save refresh timer

  alsi_pkg::alsi_state_e state_reg, state_next;
  logic [15:0] pre_reg, pre_next;
  alsi_pkg::alsi_ms_t ms_reg, ms_next;
  alsi_pkg::alsi_ms_t period_reg, period_next;
  logic pulse_reg, pulse_next;
  logic [15:0] res_reg, res_next;
  logic scale_ok_reg, scale_ok_next;
  logic power_save_on;
  logic [15:0] pre_last;

  always_comb begin
    power_save_on = psave_reg[`ALSI_PSON_BIT];
    pre_last = 16'(MS_CYCLES - 1);
    period_next = period_ms(psave_reg[`ALSI_WAIT_MSB:`ALSI_WAIT_LSB], integration_time_code);
    res_next = res_of(integration_time_code);
    scale_ok_next = (gain_code == `ALSI_GAIN_NOM);
    state_next = state_reg;
    pre_next = pre_reg;
    ms_next = ms_reg;
    pulse_next = 1'b0;
    case (state_reg)
      alsi_pkg::ALSI_IDLE: begin
        pre_next = `ALSI_ZERO16;
        ms_next = 13'h0000;
        if (power_save_on) begin
          state_next = alsi_pkg::ALSI_RUN;
        end
      end
      alsi_pkg::ALSI_RUN: begin
        if (!power_save_on) begin
          state_next = alsi_pkg::ALSI_IDLE;
        end else if (pre_reg >= pre_last) begin
          pre_next = `ALSI_ZERO16;
          if (ms_reg + `ALSI_ONE13 >= period_reg) begin
            ms_next = 13'h0000;
            pulse_next = 1'b1;
          end else begin
            ms_next = ms_reg + `ALSI_ONE13;
          end
        end else begin
          pre_next = pre_reg + `ALSI_ONE16;
        end
      end
      default: state_next = alsi_pkg::ALSI_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= alsi_pkg::ALSI_IDLE;
      pre_reg <= `ALSI_ZERO16;
      ms_reg <= 13'h0000;
      period_reg <= `ALSI_BASE_W0;
      pulse_reg <= 1'b0;
      res_reg <= `ALSI_RES_IT0;
      scale_ok_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pre_reg <= pre_next;
      ms_reg <= ms_next;
      period_reg <= period_next;
      pulse_reg <= pulse_next;
      res_reg <= res_next;
      scale_ok_reg <= scale_ok_next;
    end
  end

  assign cmd_rdata = rdata_reg;
  assign cmd_rvalid = rvalid_reg;
  assign refresh_pulse = pulse_reg;
  assign refresh_period_ms = period_reg;
  assign lx_per_count = res_reg;
  assign lx_scale_valid = scale_ok_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  status_read_a: assert property (status_rd |=> cmd_rdata[15:14] ==
      {$past(low_crossing_flag_reg), $past(high_crossing_flag_reg)} && cmd_rvalid)
    else $error("status read data wrong");
  low_set_a: assert property (low_hit |=> low_crossing_flag_reg)
    else $error("low crossing flag not set");
  high_set_a: assert property (high_hit |=> high_crossing_flag_reg)
    else $error("high crossing flag not set");
  reserved_zero_a: assert property (status_rd |=> cmd_rdata[13:0] == 14'h0000)
    else $error("reserved status bits not zero");
  no_refresh_off_a: assert property (!power_save_on |=> !refresh_pulse)
    else $error("refresh while power save off");
  base_period_a: assert property (psave_reg[2:1] == 2'h3 && integration_time_code == 4'h0
      |=> refresh_period_ms == 13'd4100)
    else $error("base refresh period wrong");
  max_period_a: assert property (psave_reg[2:1] == 2'h3 && integration_time_code == 4'h3
      |=> refresh_period_ms == 13'd4800)
    else $error("longest refresh period wrong");
  scale_a: assert property (integration_time_code == 4'h1 |=> lx_per_count == 16'd144)
    else $error("count resolution wrong");
  psave_wr_a: assert property (cmd_wr && cmd_code == 8'h03 |=>
      psave_reg == $past(cmd_wdata[2:0]))
    else $error("power save register not written");
  clear_read_a: assert property (status_rd && !low_hit && !high_hit
      |=> !low_crossing_flag_reg && !high_crossing_flag_reg)
    else $error("flags not cleared by read");

  refresh_seen_c: cover property (refresh_pulse);
  low_read_c: cover property (low_crossing_flag_reg && status_rd);
  set_clear_c: cover property (status_rd && low_hit);
  both_flags_c: cover property (low_crossing_flag_reg && high_crossing_flag_reg);

endmodule // alsi_top
`default_nettype wire

/* File: testbench/alsi_host_model.sv */
// host side model: drives the command port with strobes and 16-bit words
// assumes ref_clk from the bench; changes lines at the falling edge
`timescale 1ns/1ps
`default_nettype none
module alsi_host_model (
  input wire logic ref_clk,
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_rvalid
);
  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////
  // register writes and reads
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge ref_clk);
    cmd_wr = 1'b1;
    cmd_code = c;
    cmd_wdata = d;
    @(negedge ref_clk);
    cmd_wr = 1'b0;
    cmd_code = ~c;
    cmd_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic v);
    @(negedge ref_clk);
    cmd_rd = 1'b1;
    cmd_code = c;
    @(negedge ref_clk);
    cmd_rd = 1'b0;
    cmd_code = ~c;
    d = cmd_rdata;
    v = cmd_rvalid;
  endtask
endmodule // alsi_host_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// bench for the status register and power-save refresh timer
// assumes the host model for command traffic; MS_CYCLES cut to 4
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk, reset, cmd_wr, cmd_rd, cmd_rvalid, result_valid, int_enable;
  logic refresh_pulse, lx_scale_valid, v;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, light_result, high_threshold, lx_per_count, d;
  logic [3:0] integration_time_code;
  logic [1:0] gain_code;
  logic [12:0] refresh_period_ms;
  logic [15:0] base [4] = '{16'h0258, 16'h044c, 16'h0834, 16'h1004};
  logic [15:0] add [4] = '{16'h0000, 16'h0064, 16'h012c, 16'h02bc};
  logic [15:0] res [4] = '{16'h0120, 16'h0090, 16'h0048, 16'h0024};
  int mismatches = 0;
  int compares = 0;
  int n;
  alsi_top #(.MS_CYCLES(4)) dut (.ref_clk(ref_clk), .reset(reset), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .cmd_rvalid(cmd_rvalid), .result_valid(result_valid), .light_result(light_result),
    .high_threshold(high_threshold), .int_enable(int_enable),
    .integration_time_code(integration_time_code), .gain_code(gain_code),
    .refresh_pulse(refresh_pulse), .refresh_period_ms(refresh_period_ms),
    .lx_per_count(lx_per_count), .lx_scale_valid(lx_scale_valid));
  alsi_host_model host (.ref_clk(ref_clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .cmd_rvalid(cmd_rvalid));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] c, input logic [15:0] exp);
    host.rd(c, d, v);
    chk({15'h0000, v}, 16'h0001);
    chk(d, exp);
  endtask
  task automatic hit(input logic [15:0] r);
    @(negedge ref_clk);
    result_valid = 1'b1;
    light_result = r;
    @(negedge ref_clk);
    result_valid = 1'b0;
    light_result = ~r;
  endtask
  task automatic wait_pulse(input int lim);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (refresh_pulse !== 1'b1 && n < lim);
    if (n >= lim) begin
      mismatches++;
      finish_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    result_valid = 1'b0;
    light_result = 16'h0000;
    high_threshold = 16'h00c8;
    int_enable = 1'b1;
    integration_time_code = 4'h0;
    gain_code = 2'h1;
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    chk({3'h0, refresh_period_ms}, 16'h0258);
    chk(lx_per_count, 16'h0120);
    chk({15'h0000, lx_scale_valid}, 16'h0000);
    @(negedge ref_clk);
    chk({15'h0000, lx_scale_valid}, 16'h0001);
    rchk(8'h06, 16'h0000);
    host.wr(8'h02, 16'h0064);
    rchk(8'h02, 16'h0064);
    hit(16'h0032);
    rchk(8'h06, 16'h8000);
    rchk(8'h06, 16'h0000);
    hit(16'h012c);
    rchk(8'h06, 16'h4000);
    hit(16'h0063);
    hit(16'h00c9);
    rchk(8'h06, 16'hc000);
    hit(16'h0064);
    hit(16'h00c8);
    rchk(8'h06, 16'h0000);
    int_enable = 1'b0;
    hit(16'h0001);
    rchk(8'h06, 16'h0000);
    int_enable = 1'b1;
    hit(16'h0001);
    host.wr(8'h06, 16'h0000);
    rchk(8'h06, 16'h8000);
    rchk(8'h07, 16'h0000);
    for (int w = 0; w < 4; w++) begin
      for (int i = 0; i < 4; i++) begin
        host.wr(8'h03, {13'h0000, w[1:0], 1'b0});
        integration_time_code = i[3:0];
        repeat (2) @(negedge ref_clk);
        chk({3'h0, refresh_period_ms}, base[w] + add[i]);
        chk(lx_per_count, res[i]);
      end
    end
    gain_code = 2'h2;
    repeat (2) @(negedge ref_clk);
    chk({15'h0000, lx_scale_valid}, 16'h0000);
    integration_time_code = 4'h0;
    host.wr(8'h03, 16'hfff9);
    rchk(8'h03, 16'h0001);
    wait_pulse(3000);
    wait_pulse(3000);
    chk(n[15:0], 16'h0960);
    integration_time_code = 4'h1;
    host.wr(8'h03, 16'h0003);
    wait_pulse(6000);
    wait_pulse(6000);
    chk(n[15:0], 16'h12c0);
    host.wr(8'h03, 16'h0000);
    n = 0;
    repeat (5000) begin
      @(negedge ref_clk);
      n += int'(refresh_pulse === 1'b1);
    end
    chk(n[15:0], 16'h0000);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
